// ---- pkg/acf_pkg.sv ----
// shared types and constants for the ipv6 access entry classifier
package acf_pkg;
    localparam int unsigned ADDR_W = 128;
    localparam int unsigned PFX_W = 8;
    localparam int unsigned PORT_W = 16;
    localparam int unsigned PROTO_W = 8;
    localparam int unsigned SEQ_W = 4;
    localparam int unsigned NUM_ENTRIES = 4;
    localparam logic [PFX_W-1:0] PFX_FULL = 8'h80;
    // flag bit positions inside the frame flag vector
    localparam int unsigned FLG_URG = 3;
    localparam int unsigned FLG_ACK = 2;
    localparam int unsigned FLG_PSH = 1;
    localparam int unsigned FLG_RST = 0;

    typedef enum logic [1:0] {
        ACF_ACT_PERMIT = 2'h0,
        ACF_ACT_DENY = 2'h1,
        ACF_ACT_SHUTDOWN = 2'h2
    } acf_action_e;

    typedef enum logic [1:0] {
        ACF_PORT_ANY = 2'h0,
        ACF_PORT_SINGLE = 2'h1,
        ACF_PORT_RANGE = 2'h2
    } acf_port_sel_e;

    typedef enum logic [1:0] {
        ACF_FLAG_DONT_CARE = 2'h0,
        ACF_FLAG_SET = 2'h1,
        ACF_FLAG_UNSET = 2'h2
    } acf_flag_sel_e;

    // one access entry as configured by software
    typedef struct packed {
        logic valid;
        logic [SEQ_W-1:0] seq;
        acf_action_e action;
        logic proto_any;
        logic [PROTO_W-1:0] proto;
        logic src_any;
        logic [ADDR_W-1:0] src_addr;
        logic [PFX_W-1:0] source_address_prefix;
        logic dst_any;
        logic [ADDR_W-1:0] dst_addr;
        logic [PFX_W-1:0] destination_address_prefix;
        acf_port_sel_e sport_sel;
        logic [PORT_W-1:0] sport_lo;
        logic [PORT_W-1:0] sport_hi;
        acf_port_sel_e dport_sel;
        logic [PORT_W-1:0] dport_lo;
        logic [PORT_W-1:0] dport_hi;
        acf_flag_sel_e urg_sel;
        acf_flag_sel_e ack_sel;
        acf_flag_sel_e psh_sel;
        acf_flag_sel_e rst_sel;
    } acf_entry_s;

    // parsed header fields of one frame
    typedef struct packed {
        logic [PROTO_W-1:0] proto;
        logic [ADDR_W-1:0] src_addr;
        logic [ADDR_W-1:0] dst_addr;
        logic [PORT_W-1:0] sport;
        logic [PORT_W-1:0] dport;
        logic [3:0] flags;
    } acf_frame_s;

    // forwarding verdict for one frame
    typedef struct packed {
        logic hit;
        logic forward;
        logic learn;
        logic drop;
        logic shutdown;
        logic [SEQ_W-1:0] seq;
    } acf_result_s;
endpackage

// ---- rtl/acf_classifier.sv ----
// ipv6 access entry classifier: one-cycle verdict per frame
`timescale 1ns/1ps
module acf_classifier (
    input wire logic core_clk_i, // 250 mhz core clock
    input wire logic resetn_i, // async reset, active low
    input wire acf_pkg::acf_entry_s [acf_pkg::NUM_ENTRIES-1:0] entries_i, // list
    input wire logic frame_valid_i, // frame header present
    input wire acf_pkg::acf_frame_s frame_i, // parsed header fields
    output logic result_valid_o, // verdict strobe
    output acf_pkg::acf_result_s result_o // verdict fields
);

    // prefix compare of two addresses over the leading plen bits
    function automatic logic addr_match(
        input logic [acf_pkg::ADDR_W-1:0] a,
        input logic [acf_pkg::ADDR_W-1:0] b,
        input logic [acf_pkg::PFX_W-1:0] plen
    );
        logic [acf_pkg::ADDR_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < acf_pkg::ADDR_W; i++) begin
            mask[acf_pkg::ADDR_W-1-i] = (i < int'(plen));
        end
        if (plen > acf_pkg::PFX_FULL) begin
            mask = '1;
        end
        return ((a ^ b) & mask) == '0;
    endfunction

    // layer-4 port compare for any, single and range selectors
    function automatic logic port_match(
        input acf_pkg::acf_port_sel_e sel,
        input logic [acf_pkg::PORT_W-1:0] p,
        input logic [acf_pkg::PORT_W-1:0] lo,
        input logic [acf_pkg::PORT_W-1:0] hi
    );
        logic r;
        r = 1'b0;
        unique case (sel)
            acf_pkg::ACF_PORT_ANY: r = 1'b1;
            acf_pkg::ACF_PORT_SINGLE: r = (p == lo);
            acf_pkg::ACF_PORT_RANGE: r = (p >= lo) && (p <= hi);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // three-state tcp flag compare
    function automatic logic flag_match(
        input acf_pkg::acf_flag_sel_e sel,
        input logic bit_v
    );
        logic r;
        r = 1'b0;
        unique case (sel)
            acf_pkg::ACF_FLAG_DONT_CARE: r = 1'b1;
            acf_pkg::ACF_FLAG_SET: r = bit_v;
            acf_pkg::ACF_FLAG_UNSET: r = ~bit_v;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    logic [acf_pkg::NUM_ENTRIES-1:0] hit_vec;
    logic result_valid_d;
    logic result_valid_q;
    acf_pkg::acf_result_s result_d;
    acf_pkg::acf_result_s result_q;

    // per-entry field comparison
    always_comb begin
        for (int e = 0; e < acf_pkg::NUM_ENTRIES; e++) begin
            hit_vec[e] = entries_i[e].valid
                && (entries_i[e].proto_any
                    || entries_i[e].proto == frame_i.proto)
                && (entries_i[e].src_any
                    || addr_match(frame_i.src_addr, entries_i[e].src_addr,
                        entries_i[e].source_address_prefix))
                && (entries_i[e].dst_any
                    || addr_match(frame_i.dst_addr, entries_i[e].dst_addr,
                        entries_i[e].destination_address_prefix))
                && port_match(entries_i[e].sport_sel, frame_i.sport,
                    entries_i[e].sport_lo, entries_i[e].sport_hi)
                && port_match(entries_i[e].dport_sel, frame_i.dport,
                    entries_i[e].dport_lo, entries_i[e].dport_hi)
                && flag_match(entries_i[e].urg_sel,
                    frame_i.flags[acf_pkg::FLG_URG])
                && flag_match(entries_i[e].ack_sel,
                    frame_i.flags[acf_pkg::FLG_ACK])
                && flag_match(entries_i[e].psh_sel,
                    frame_i.flags[acf_pkg::FLG_PSH])
                && flag_match(entries_i[e].rst_sel,
                    frame_i.flags[acf_pkg::FLG_RST]);
        end
    end

    // verdict selection and action decode
    always_comb begin
        logic found;
        logic [acf_pkg::SEQ_W-1:0] best_seq;
        acf_pkg::acf_action_e best_act;
        found = 1'b0;
        best_seq = '0;
        best_act = acf_pkg::ACF_ACT_PERMIT;
        for (int e = 0; e < acf_pkg::NUM_ENTRIES; e++) begin
            if (hit_vec[e] && (!found || entries_i[e].seq < best_seq)) begin
                found = 1'b1;
                best_seq = entries_i[e].seq;
                best_act = entries_i[e].action;
            end
        end
        result_valid_d = frame_valid_i;
        result_d = '0;
        result_d.hit = found;
        result_d.seq = best_seq;
        // no matching entry: frame passes untouched
        result_d.forward = 1'b1;
        result_d.learn = 1'b1;
        if (found) begin
            unique case (best_act)
                acf_pkg::ACF_ACT_PERMIT: begin
                    result_d.forward = 1'b1;
                    result_d.learn = 1'b1;
                end
                acf_pkg::ACF_ACT_DENY: begin
                    result_d.forward = 1'b0;
                    result_d.learn = 1'b0;
                    result_d.drop = 1'b1;
                end
                acf_pkg::ACF_ACT_SHUTDOWN: begin
                    result_d.forward = 1'b0;
                    result_d.learn = 1'b0;
                    result_d.drop = 1'b1;
                    result_d.shutdown = 1'b1;
                end
                default: begin
                    result_d.forward = 1'b0;
                    result_d.learn = 1'b0;
                    result_d.drop = 1'b1;
                end
            endcase
        end
        if (!frame_valid_i) begin
            result_d = '0;
        end
    end

    // output registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_valid_q <= 1'b0;
            result_q <= '0;
        end else begin
            result_valid_q <= result_valid_d;
            result_q <= result_d;
        end
    end

    assign result_valid_o = result_valid_q;
    assign result_o = result_q;

    a_permit_forward: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        result_valid_o && result_o.hit && !result_o.drop
            |-> result_o.forward && result_o.learn)
        else $error("permit verdict not forwarded");

    a_drop_no_forward: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        result_o.drop |-> !result_o.forward && result_o.hit)
        else $error("dropped frame also forwarded");

    a_shutdown_drops: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        result_o.shutdown |-> result_o.drop)
        else $error("shutdown without drop");

    a_valid_follows: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        frame_valid_i |=> result_valid_o)
        else $error("verdict missing after frame");

    a_miss_passes: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        result_valid_o && !result_o.hit |-> result_o.forward)
        else $error("unmatched frame not forwarded");

    a_hit_reported: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        frame_valid_i && (hit_vec != '0) |=> result_o.hit)
        else $error("matching entry not reported");

    a_idle_clear: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !frame_valid_i |=> !result_o.hit && !result_o.drop)
        else $error("verdict without frame");

    a_seq_stable: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        frame_valid_i && $stable(entries_i) && $stable(frame_i)
            && $past(frame_valid_i) |=> $stable(result_o))
        else $error("verdict changed with same inputs");

    a_proto_blocks: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !entries_i[0].proto_any && entries_i[0].proto != frame_i.proto
            |-> !hit_vec[0])
        else $error("entry hit with wrong protocol");

    a_src_full: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        !entries_i[0].src_any
            && entries_i[0].source_address_prefix == acf_pkg::PFX_FULL
            && entries_i[0].src_addr != frame_i.src_addr |-> !hit_vec[0])
        else $error("entry hit with wrong source address");

    a_sport_single: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        entries_i[0].sport_sel == acf_pkg::ACF_PORT_SINGLE
            && frame_i.sport != entries_i[0].sport_lo |-> !hit_vec[0])
        else $error("entry hit with wrong source port");

    a_sport_range: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        entries_i[0].sport_sel == acf_pkg::ACF_PORT_RANGE
            && (frame_i.sport < entries_i[0].sport_lo
                || frame_i.sport > entries_i[0].sport_hi) |-> !hit_vec[0])
        else $error("entry hit outside source range");

    a_dport_single: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        entries_i[0].dport_sel == acf_pkg::ACF_PORT_SINGLE
            && frame_i.dport != entries_i[0].dport_lo |-> !hit_vec[0])
        else $error("entry hit with wrong destination port");

    a_dport_range: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        entries_i[0].dport_sel == acf_pkg::ACF_PORT_RANGE
            && (frame_i.dport < entries_i[0].dport_lo
                || frame_i.dport > entries_i[0].dport_hi) |-> !hit_vec[0])
        else $error("entry hit outside destination range");

    a_urg_set: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        entries_i[0].urg_sel == acf_pkg::ACF_FLAG_SET
            && !frame_i.flags[acf_pkg::FLG_URG] |-> !hit_vec[0])
        else $error("entry hit with urg clear");

    a_rst_unset: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        entries_i[0].rst_sel == acf_pkg::ACF_FLAG_UNSET
            && frame_i.flags[acf_pkg::FLG_RST] |-> !hit_vec[0])
        else $error("entry hit with rst set");

    a_deny_drops: assert property (@(posedge core_clk_i)
        disable iff (!resetn_i)
        frame_valid_i && hit_vec == 4'h1
            && entries_i[0].action == acf_pkg::ACF_ACT_DENY
            |=> result_o.drop && !result_o.forward && !result_o.learn)
        else $error("denied frame not dropped");

endmodule // acf_classifier

// ---- test/acf_ingress_model.sv ----
// ingress pipeline model that presents parsed frame headers
`timescale 1ns/1ps
module acf_ingress_model (
    input wire logic core_clk_i, // core clock
    output logic frame_valid_o, // header present
    output acf_pkg::acf_frame_s frame_o // parsed header fields
);
    // idle bus before the first header
    initial begin
        frame_valid_o = 1'b0;
        frame_o = '0;
    end
    // one header per edge; a released bus shows the inverse pattern
    task automatic send(input acf_pkg::acf_frame_s f, input bit hold);
        frame_valid_o <= 1'b1;
        frame_o <= f;
        @(posedge core_clk_i);
        if (!hold) begin
            frame_valid_o <= 1'b0;
            frame_o <= ~f;
            @(posedge core_clk_i);
        end
    endtask
endmodule // acf_ingress_model

// ---- test/tb_top.sv ----
// self-checking bench for the ipv6 access entry classifier
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    miscompares++; $display("wrong value %s expected %h seen %h", n, e, g); \
    end end
module tb_top;
    logic clk, rstn, fv, rv, pend_q;
    acf_pkg::acf_entry_s [acf_pkg::NUM_ENTRIES-1:0] ent;
    acf_pkg::acf_entry_s en, base;
    acf_pkg::acf_frame_s fr;
    acf_pkg::acf_result_s res, exp_q;
    int miscompares = 0, tests_run = 0, cycles = 0;
    integer seed = 56764;
    acf_classifier acf_classifier_i (.core_clk_i(clk), .resetn_i(rstn),
        .entries_i(ent), .frame_valid_i(fv), .frame_i(fr),
        .result_valid_o(rv), .result_o(res));
    acf_ingress_model acf_ingress_model_i (.core_clk_i(clk),
        .frame_valid_o(fv), .frame_o(fr));
    function automatic int rn(int m);
        return $unsigned($random(seed)) % m;
    endfunction
    function automatic logic [1:0] sel3();
        int r = rn(13);
        return (r == 12) ? 2'h3 : 2'(r % 3);
    endfunction
    function automatic bit addr_ok(logic any, logic [127:0] a, c,
            logic [7:0] pl);
        int n = (pl > 8'h80) ? acf_pkg::ADDR_W : int'(pl);
        logic [127:0] m = '1 << (acf_pkg::ADDR_W - n);
        return any || ((a & m) == (c & m));
    endfunction
    function automatic bit port_ok(acf_pkg::acf_port_sel_e s,
            logic [15:0] p, lo, hi);
        return s == acf_pkg::ACF_PORT_ANY ||
            (s == acf_pkg::ACF_PORT_SINGLE && p == lo) ||
            (s == acf_pkg::ACF_PORT_RANGE && p >= lo && p <= hi);
    endfunction
    function automatic bit flag_ok(acf_pkg::acf_flag_sel_e s, logic b);
        return s == acf_pkg::ACF_FLAG_DONT_CARE ||
            (s == acf_pkg::ACF_FLAG_SET && b === 1'b1) ||
            (s == acf_pkg::ACF_FLAG_UNSET && b === 1'b0);
    endfunction
    function automatic acf_pkg::acf_result_s verdict(acf_pkg::acf_frame_s f);
        acf_pkg::acf_result_s r = '0;
        acf_pkg::acf_entry_s e;
        {r.forward, r.learn} = 2'h3;
        for (int i = acf_pkg::NUM_ENTRIES - 1; i >= 0; i--) begin
            e = ent[i];
            if (e.valid && (e.proto_any || e.proto == f.proto) &&
                addr_ok(e.src_any, f.src_addr, e.src_addr,
                    e.source_address_prefix) &&
                addr_ok(e.dst_any, f.dst_addr, e.dst_addr,
                    e.destination_address_prefix) &&
                port_ok(e.sport_sel, f.sport, e.sport_lo, e.sport_hi) &&
                port_ok(e.dport_sel, f.dport, e.dport_lo, e.dport_hi) &&
                flag_ok(e.urg_sel, f.flags[acf_pkg::FLG_URG]) &&
                flag_ok(e.ack_sel, f.flags[acf_pkg::FLG_ACK]) &&
                flag_ok(e.psh_sel, f.flags[acf_pkg::FLG_PSH]) &&
                flag_ok(e.rst_sel, f.flags[acf_pkg::FLG_RST]) &&
                (!r.hit || e.seq <= r.seq)) begin
                r.hit = 1'b1;
                r.seq = e.seq;
                r.forward = e.action == acf_pkg::ACF_ACT_PERMIT;
                r.learn = r.forward;
                r.drop = !r.forward;
                r.shutdown = e.action == acf_pkg::ACF_ACT_SHUTDOWN;
            end
        end
        return r;
    endfunction
    function automatic acf_pkg::acf_entry_s rnd_entry();
        acf_pkg::acf_entry_s e;
        logic [7:0] pl[6] = '{8'h0, 8'h1, 8'h40, 8'h7f, 8'h80, 8'hc8};
        for (int b = 0; b < $bits(e); b++) e[b] = 1'($random(seed));
        e.valid = rn(6) != 0;
        e.source_address_prefix = pl[rn(6)];
        e.destination_address_prefix = pl[rn(6)];
        e.sport_hi = e.sport_lo + 16'(rn(8)) - 16'(rn(2));
        e.dport_hi = e.dport_lo + 16'(rn(8));
        e.sport_sel = acf_pkg::acf_port_sel_e'(sel3());
        e.dport_sel = acf_pkg::acf_port_sel_e'(sel3());
        e.urg_sel = acf_pkg::acf_flag_sel_e'(sel3());
        e.ack_sel = acf_pkg::acf_flag_sel_e'(sel3());
        e.psh_sel = acf_pkg::acf_flag_sel_e'(sel3());
        e.rst_sel = acf_pkg::acf_flag_sel_e'(sel3());
        return e;
    endfunction
    function automatic logic [127:0] flip(logic [127:0] a, logic [7:0] pl);
        int k = rn(4);
        int b = (k == 0) ? 128 - int'(pl) : (k == 1) ? 127 - int'(pl) : rn(256);
        return (b >= 0 && b < 128) ? a ^ (128'h1 << b) : a;
    endfunction
    function automatic logic [15:0] pick(logic [15:0] lo, hi);
        case (rn(5))
            0: return lo;
            1: return hi;
            2: return lo - 16'h1;
            3: return hi + 16'h1;
            default: return 16'($random(seed));
        endcase
    endfunction
    function automatic acf_pkg::acf_frame_s rnd_frame();
        acf_pkg::acf_entry_s e = ent[rn(acf_pkg::NUM_ENTRIES)];
        acf_pkg::acf_frame_s f;
        f.proto = rn(2) ? e.proto : 8'($random(seed));
        f.src_addr = flip(e.src_addr, e.source_address_prefix);
        f.dst_addr = flip(e.dst_addr, e.destination_address_prefix);
        f.sport = pick(e.sport_lo, e.sport_hi);
        f.dport = pick(e.dport_lo, e.dport_hi);
        f.flags = 4'($random(seed));
        return f;
    endfunction
    task automatic print_verdict();
        if (miscompares == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // clock generation
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // expected verdict one edge after each taken frame, and hang guard
    always @(posedge clk) begin
        pend_q <= fv && rstn;
        exp_q <= verdict(fr);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // compare settled outputs mid-cycle
    always @(negedge clk) if (rstn) begin
        `CHK("result valid", pend_q, rv)
        if (pend_q) begin
            `CHK("verdict flags", exp_q[8:4], res[8:4])
            `CHK("hit sequence", exp_q.seq, res.seq)
        end else `CHK("idle result", 9'h0, res)
    end
    // random entry lists with bursts of back-to-back frames
    initial begin
        rstn = 1'b0;
        ent = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int it = 0; it < 300; it++) begin
            @(posedge clk);
            base = rnd_entry();
            for (int i = 0; i < acf_pkg::NUM_ENTRIES; i++) begin
                en = rnd_entry();
                if (it % 4 == 0) begin
                    en = base;
                    en.action = acf_pkg::acf_action_e'(i);
                    en.seq = 4'(rn(2));
                    en.valid = 1'b1;
                end
                ent[i] <= en;
            end
            @(posedge clk);
            for (int k = 0; k < 6; k++)
                acf_ingress_model_i.send(rnd_frame(), k < 5 && rn(2));
            if (it == 200) begin
                rstn <= 1'b0;
                #1 `CHK("reset valid", 1'b0, rv)
                `CHK("reset result", 9'h0, res)
                @(posedge clk);
                rstn <= 1'b1;
            end
        end
        print_verdict();
    end
endmodule // tb_top
